// ---- rtl/wlc_regs.svh ----
`ifndef WLC_REGS_SVH
`define WLC_REGS_SVH
// register word addresses on the plain register port
`define WLC_ADDR_WATCHDOG_CONTROL   4'h0
`define WLC_ADDR_LPCFG  4'h1
`define WLC_ADDR_WAKE   4'h2
`define WLC_ADDR_SYSCTL 4'h3
// watchdog_control field positions
`define WLC_PS_MSB      2
`define WLC_CHK_MSB     5
`define WLC_CHK_LSB     3
`define WLC_DIS_BIT     6
`define WLC_FLAG_BIT    7
`define WLC_CHK_GOOD    3'h5
// system_control_status field positions
`define WLC_OVR_BIT     0
`define WLC_INTEN_BIT   1
// reset values
`define WLC_LPCFG_RST   8'hfc
`define WLC_WAKE_RST    16'h0000
`define WLC_SYS_RST     2'h1
// timing counts, in oscillator cycles
`define WLC_PRE_MAX     9'h1ff
`define WLC_PULSE_CYC   10'h200
`define WLC_FLAG_DLY    4
`endif

// ---- rtl/wlc_pkg.sv ----
package wlc_pkg;
   // low-power sequencer states
   typedef enum logic [2:0] {
      WLC_NORMAL,
      WLC_IDLE,
      WLC_STANDBY,
      WLC_QUAL,
      WLC_HALT,
      WLC_RECOVER
   } wlc_state_t;
   // watchdog_control as stored
   typedef struct packed {
      logic       flag;
      logic       dis;
      logic [2:0] ps;
   } wlc_watchdog_control_t;
   // debugger status from the core
   typedef struct packed {
      logic suspend;
      logic run_free;
      logic rt_step;
      logic rt_free;
      logic wake;
   } wlc_dbg_t;
   // wake pins, all wake on a low level
   typedef struct packed {
      logic       can_rx;
      logic       sci_rx_b;
      logic       sci_rx_a;
      logic [5:0] compare_trip_n;
      logic [3:0] timer_trip_n;
      logic       nmi_n;
      logic       ext_int_one_n;
   } wlc_pins_t;
endpackage

// ---- rtl/wlc_top.sv ----
// Decided for this implementation: the plain strobed port and the register addresses.
`include "wlc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module wlc_top
   import wlc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        ext_reset_pin_n,
   input  wire wlc_pins_t   wake_pins,
   input  wire wlc_dbg_t    dbg,
   input  wire logic        wd_overflow,
   input  wire logic        idle_status,
   input  wire logic        int_recognised,
   output logic             count_tick,
   output logic             core_reset_req,
   output logic             wd_reset_pulse_n,
   output logic             wd_interrupt_n,
   output logic             core_clk_en,
   output logic             sysclk_en,
   output logic             osc_en
);
   // divisor minus one after the 512 stage
   function automatic logic [5:0] wlc_post_max(input logic [2:0] ps);
      logic [5:0] m;
      m = 6'h00;
      if (ps > 3'h1)
         m = 6'((7'h01 << (ps - 3'h1)) - 7'h01);
      return m;
   endfunction

   wlc_watchdog_control_t   watchdog_control_q;
   logic [7:0]  lpcfg_q;
   logic [15:0] wake_en_q;
   logic [1:0]  sys_q;
   logic [15:0] rdata_q;
   logic [8:0]  pre_q;
   logic [5:0]  post_q;
   logic        tick_q;
   logic        crr_q;
   logic [9:0]  pulse_q;
   logic [9:0]  pulse_d;
   logic        pulse_n_q;
   logic        int_n_q;
   logic [1:0]  xrs_sync_q;
   logic [15:0] pin_sync1_q;
   logic [15:0] pin_sync2_q;
   logic [`WLC_FLAG_DLY+1:0] flag_pipe_q;
   wlc_state_t  state_q;
   wlc_state_t  state_d;
   wlc_state_t  mode_q;
   logic [5:0]  qual_q;
   logic        idle_prev_q;
   logic        core_en_q;
   logic        sys_en_q;
   logic        osc_en_q;

   logic xrs_s;
   logic wr_watchdog_control;
   logic chk_ok;
   logic chk_fail;
   logic wr_good;
   logic dbg_stop;
   logic run_cnt;
   logic fire;
   logic flag_rise;
   logic idle_rise;
   logic [15:0] wake_vec;
   logic [15:0] wake_low;
   logic any_low;
   wlc_state_t sel_mode;

   assign xrs_s    = xrs_sync_q[1];
   assign wr_watchdog_control  = wr && (addr == `WLC_ADDR_WATCHDOG_CONTROL);
   assign chk_ok   = wdata[`WLC_CHK_MSB:`WLC_CHK_LSB] == `WLC_CHK_GOOD;
   assign wr_good  = wr_watchdog_control && chk_ok;
   // a bad pattern only resets while the watchdog is enabled
   assign chk_fail = wr_watchdog_control && !chk_ok && !watchdog_control_q.dis;

   // debug stops: single-step wins, either run-free releases suspend
   assign dbg_stop = dbg.rt_step ||
                     (dbg.suspend && !dbg.run_free &&
                      !dbg.rt_free);
   // watchdog has no clock in halt
   assign run_cnt  = !watchdog_control_q.dis && !dbg_stop &&
                     (state_q != WLC_HALT);

   // overflow from the counter only counts while enabled
   assign fire = chk_fail || (wd_overflow && run_cnt);

   // standby wake vector, bit order follows the wake-enable layout
   assign wake_vec = {pin_sync2_q[15:3], int_n_q, pin_sync2_q[1:0]};
   assign wake_low = ~wake_vec & wake_en_q;
   assign any_low  = |wake_low;
   assign idle_rise = idle_status && !idle_prev_q;
   assign sel_mode = lpcfg_q[1] ? WLC_HALT :
                     (lpcfg_q[0] ? WLC_STANDBY : WLC_IDLE);

   // two-stage sync of the reset pin and wake pins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         xrs_sync_q  <= 2'h0;
         pin_sync1_q <= 16'hffff;
         pin_sync2_q <= 16'hffff;
      end
      else
      begin
         xrs_sync_q  <= {xrs_sync_q[0], ext_reset_pin_n};
         pin_sync1_q <= {wake_pins[14:2], 1'b1, wake_pins[1:0]};
         pin_sync2_q <= pin_sync1_q;
      end
   end

   // watchdog_control in one process so the word has a single driver;
   // a failed check leaves every field alone, flag set beats the write clear, the reset pin clear beats the set
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         watchdog_control_q.ps   <= 3'h0;
         watchdog_control_q.dis  <= 1'b0;
         watchdog_control_q.flag <= 1'b0;
      end
      else
      begin
         if (wr_good)
         begin
            watchdog_control_q.ps <= wdata[`WLC_PS_MSB:0];
            if (sys_q[`WLC_OVR_BIT])
               watchdog_control_q.dis <= wdata[`WLC_DIS_BIT];
         end
         if (!xrs_s)
            watchdog_control_q.flag <= 1'b0;
         else if (flag_rise)
            watchdog_control_q.flag <= 1'b1;
         else if (wr_good && wdata[`WLC_FLAG_BIT])
            watchdog_control_q.flag <= 1'b0;
      end
   end

   // pulse passes two sync stages plus the fixed delay
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_pipe_q <= '1;
      else
         flag_pipe_q <= {flag_pipe_q[`WLC_FLAG_DLY:0], pulse_n_q};
   end
   assign flag_rise = flag_pipe_q[`WLC_FLAG_DLY] &&
                      !flag_pipe_q[`WLC_FLAG_DLY+1];

   // other configuration registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lpcfg_q   <= `WLC_LPCFG_RST;
         wake_en_q <= `WLC_WAKE_RST;
         sys_q     <= `WLC_SYS_RST;
      end
      else if (wr)
      begin
         if (addr == `WLC_ADDR_LPCFG)
            lpcfg_q <= wdata[7:0];
         if (addr == `WLC_ADDR_WAKE)
            wake_en_q <= wdata;
         if (addr == `WLC_ADDR_SYSCTL)
            sys_q <= wdata[1:0];
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_q <= 16'h0000;
      else if (rd)
      begin
         unique case (addr)
            `WLC_ADDR_WATCHDOG_CONTROL:
               rdata_q <= {8'h00, watchdog_control_q.flag, watchdog_control_q.dis,
                           3'h0, watchdog_control_q.ps};
            `WLC_ADDR_LPCFG:  rdata_q <= {8'h00, lpcfg_q};
            `WLC_ADDR_WAKE:   rdata_q <= wake_en_q;
            `WLC_ADDR_SYSCTL: rdata_q <= {14'h0000, sys_q};
            default:          rdata_q <= 16'h0000;
         endcase
      end
      else
         rdata_q <= 16'h0000;
   end

   // 512 prescale then binary post-divider; holds while stopped
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre_q  <= 9'h000;
         post_q <= 6'h00;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= 1'b0;
         if (run_cnt)
         begin
            pre_q <= pre_q + 9'h001;
            if (pre_q == `WLC_PRE_MAX)
            begin
               if (post_q >= wlc_post_max(watchdog_control_q.ps))
               begin
                  post_q <= 6'h00;
                  tick_q <= 1'b1;
               end
               else
                  post_q <= post_q + 6'h01;
            end
         end
      end
   end

   // reset pulse length; a retrigger while low is absorbed
   always_comb
   begin
      pulse_d = pulse_q;
      if (pulse_q != 10'h000)
         pulse_d = pulse_q - 10'h001;
      else if (fire)
         pulse_d = `WLC_PULSE_CYC;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pulse_q   <= 10'h000;
         pulse_n_q <= 1'b1;
         int_n_q   <= 1'b1;
         crr_q     <= 1'b0;
      end
      else
      begin
         pulse_q   <= pulse_d;
         pulse_n_q <= pulse_d == 10'h000;
         int_n_q   <= !(pulse_d != 10'h000 &&
                        sys_q[`WLC_INTEN_BIT]);
         crr_q     <= chk_fail;
      end
   end

   // low-power sequencer
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         WLC_NORMAL:
            if (idle_rise)
               state_d = sel_mode;
         WLC_IDLE:
            // nothing to do here but watch for the exits
            if (int_recognised || !int_n_q || !xrs_s ||
                !idle_status)
               state_d = WLC_NORMAL;
         WLC_STANDBY:
            if (!xrs_s || !int_n_q || dbg.wake)
               state_d = WLC_NORMAL;
            else if (any_low)
               state_d = WLC_QUAL;
         WLC_QUAL:
            if (!xrs_s || !int_n_q || dbg.wake)
               state_d = WLC_NORMAL;
            else if (!any_low)
               state_d = WLC_STANDBY;
            else if (qual_q == lpcfg_q[7:2])
               state_d = WLC_RECOVER;
         WLC_HALT:
            if (!xrs_s || dbg.wake)
               state_d = WLC_NORMAL;
            else if (!pin_sync2_q[1])
               state_d = WLC_RECOVER;
         WLC_RECOVER:
            // clocks back on; an unrecognised wake drops back
            if (int_recognised || !idle_status || !xrs_s)
               state_d = WLC_NORMAL;
            else if ((mode_q == WLC_STANDBY && !any_low) ||
                     (mode_q == WLC_HALT && pin_sync2_q[1]))
               state_d = mode_q;
         default:
            state_d = WLC_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q     <= WLC_NORMAL;
         mode_q      <= WLC_IDLE;
         qual_q      <= 6'h00;
         idle_prev_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         idle_prev_q <= idle_status;
         if (state_q == WLC_NORMAL && idle_rise)
            mode_q <= sel_mode;
         // the first low sample counts, so field+1 more gives field+2
         if (state_q == WLC_QUAL)
            qual_q <= qual_q + 6'h01;
         else
            qual_q <= 6'h00;
      end
   end

   // clock gates follow the next state so they line up with state_q
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         core_en_q <= 1'b1;
         sys_en_q  <= 1'b1;
         osc_en_q  <= 1'b1;
      end
      else
      begin
         core_en_q <= state_d inside {WLC_NORMAL, WLC_IDLE,
                                      WLC_RECOVER};
         sys_en_q  <= state_d inside {WLC_NORMAL, WLC_IDLE,
                                      WLC_RECOVER};
         osc_en_q  <= state_d != WLC_HALT;
      end
   end

   assign rdata            = rdata_q;
   assign count_tick       = tick_q;
   assign core_reset_req   = crr_q;
   assign wd_reset_pulse_n = pulse_n_q;
   assign wd_interrupt_n   = int_n_q;
   assign core_clk_en      = core_en_q;
   assign sysclk_en        = sys_en_q;
   assign osc_en           = osc_en_q;

   // helper: length of the last low stretch of the reset pulse
   logic [10:0] low_len_q;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         low_len_q <= 11'h000;
      else if (!pulse_n_q)
         low_len_q <= low_len_q + 11'h001;
      else
         low_len_q <= 11'h000;
   end

   property p_chk_reset;
      @(posedge clk) disable iff (!arst_n)
      chk_fail |=> core_reset_req && !wd_reset_pulse_n;
   endproperty
   a_chk_reset: assert property (p_chk_reset)
      else $error("bad check pattern gave no reset");

   property p_chk_read;
      @(posedge clk) disable iff (!arst_n)
      rd && addr == `WLC_ADDR_WATCHDOG_CONTROL |=> rdata[5:3] == 3'h0;
   endproperty
   a_chk_read: assert property (p_chk_read)
      else $error("check field read nonzero");

   property p_dis_locked;
      @(posedge clk) disable iff (!arst_n)
      !sys_q[`WLC_OVR_BIT] |=> $stable(watchdog_control_q.dis);
   endproperty
   a_dis_locked: assert property (p_dis_locked)
      else $error("disable changed without override");

   property p_flag_hold;
      @(posedge clk) disable iff (!arst_n)
      watchdog_control_q.flag && xrs_s &&
      !(wr_good && wdata[`WLC_FLAG_BIT]) |=> watchdog_control_q.flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag lost without a clear");

   property p_flag_pin;
      @(posedge clk) disable iff (!arst_n)
      !xrs_s |=> !watchdog_control_q.flag;
   endproperty
   a_flag_pin: assert property (p_flag_pin)
      else $error("flag not forced low by reset pin");

   property p_flag_set;
      @(posedge clk) disable iff (!arst_n)
      $rose(wd_reset_pulse_n) && xrs_s ##1 xrs_s [*6]
      |=> watchdog_control_q.flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag not set after pulse end");

   property p_pulse_len;
      @(posedge clk) disable iff (!arst_n)
      $rose(wd_reset_pulse_n) |-> low_len_q == 11'h200;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse not 512 cycles");

   property p_dbg_stop;
      @(posedge clk) disable iff (!arst_n)
      dbg.rt_step |=> !count_tick;
   endproperty
   a_dbg_stop: assert property (p_dbg_stop)
      else $error("tick during single-step");

   property p_halt_clk;
      @(posedge clk) disable iff (!arst_n)
      state_q == WLC_HALT |-> !osc_en && !core_clk_en && !sysclk_en;
   endproperty
   a_halt_clk: assert property (p_halt_clk)
      else $error("clocks running in halt");

   property p_idle_sys;
      @(posedge clk) disable iff (!arst_n)
      state_q == WLC_IDLE |-> sysclk_en && osc_en;
   endproperty
   a_idle_sys: assert property (p_idle_sys)
      else $error("system clock stopped in idle");

   property p_idle_exit;
      @(posedge clk) disable iff (!arst_n)
      state_q == WLC_IDLE && int_recognised |=> state_q == WLC_NORMAL;
   endproperty
   a_idle_exit: assert property (p_idle_exit)
      else $error("idle not left on interrupt");

   c_standby: cover property (@(posedge clk) disable iff (!arst_n)
      state_q == WLC_STANDBY ##[1:100] state_q == WLC_RECOVER);
   c_halt: cover property (@(posedge clk) disable iff (!arst_n)
      state_q == WLC_HALT ##1 state_q == WLC_NORMAL);
   c_pulse: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(wd_reset_pulse_n));
   c_fallback: cover property (@(posedge clk) disable iff (!arst_n)
      state_q == WLC_QUAL ##1 state_q == WLC_STANDBY);
endmodule
`default_nettype wire

// ---- sim/wlc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// core side: raises idle status on request, takes a wake as an interrupt
module wlc_core_model
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic go_idle,
   input  wire logic irq,
   input  wire logic core_clk_en,
   output logic      idle_status,
   output logic      int_recognised
);
   logic clk_en_q;
   // the interrupt comes one cycle after the core clock returns, so the
   // sequencer really has to wait for it rather than leave on its own
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         idle_status    <= 1'b0;
         int_recognised <= 1'b0;
         clk_en_q       <= 1'b1;
      end
      else
      begin
         clk_en_q       <= core_clk_en;
         int_recognised <= irq || (core_clk_en && !clk_en_q);
         if (int_recognised)
            idle_status <= 1'b0;
         else if (go_idle)
            idle_status <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- sim/wlc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module wlc_top_tb_top import wlc_pkg::*;;
   logic        clk, arst_n, wr, rd, pin_n, ovf, go_idle, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata;
   wlc_pins_t   pins;
   wlc_dbg_t    dbg;
   logic        idle_st, int_rec, tick, crr, pulse_n, int_n, cen, sen, oen;
   int          error_cnt, samples_checked, np, ni, n;

   wlc_top i_wlc_top (.clk(clk), .arst_n(arst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .ext_reset_pin_n(pin_n), .wake_pins(pins), .dbg(dbg),
      .wd_overflow(ovf), .idle_status(idle_st), .int_recognised(int_rec),
      .count_tick(tick), .core_reset_req(crr), .wd_reset_pulse_n(pulse_n),
      .wd_interrupt_n(int_n), .core_clk_en(cen), .sysclk_en(sen),
      .osc_en(oen));
   wlc_core_model i_wlc_core_model (.clk(clk), .arst_n(arst_n),
      .go_idle(go_idle), .irq(irq), .core_clk_en(cen),
      .idle_status(idle_st), .int_recognised(int_rec));

   // free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic timeout();
      error_cnt++;
      end_sim();
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp,
                         input logic [15:0] m);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 chk(rdata & m, exp);
   endtask

   // cycles from the current tick to the next one
   task automatic wait_tick(output int c);
      c = 1;
      @(posedge clk) #1;
      while (tick !== 1'b1 && c < 5000)
      begin
         @(posedge clk) #1;
         c++;
      end
      if (c >= 5000)
         timeout();
   endtask

   task automatic period(input int exp);
      wait_tick(n);
      wait_tick(n);
      chk(16'(n), 16'(exp));
   endtask

   task automatic cnt_tick(input int cycles, output int c);
      c = 0;
      repeat (cycles)
      begin
         @(posedge clk) #1;
         if (tick === 1'b1)
            c++;
      end
   endtask

   // length of the reset pulse, and of the interrupt inside it
   task automatic lowcnt(output int p, output int q);
      p = 0;
      q = 0;
      // let the launching edge settle so the first low cycle is counted
      #1;
      for (int i = 0; i < 20 && pulse_n !== 1'b0; i++)
         @(posedge clk) #1;
      while (pulse_n === 1'b0 && p < 2000)
      begin
         p++;
         if (int_n === 1'b0)
            q++;
         @(posedge clk) #1;
      end
   endtask

   task automatic wait_en();
      int i;
      for (i = 0; i < 40 && cen !== 1'b1; i++)
         @(posedge clk) #1;
      if (i >= 40)
         timeout();
   endtask

   // mode field loaded before the idle request, as software must
   task automatic enter(input logic [15:0] mode, input logic [2:0] en);
      wr_reg(4'h1, mode);
      @(posedge clk) go_idle <= 1'b1;
      @(posedge clk) go_idle <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(16'({cen, sen, oen}), 16'(en));
   endtask

   task automatic wake_by(input wlc_pins_t p);
      @(posedge clk) pins <= p;
      wait_en();
      @(posedge clk) pins <= 15'h7fff;
      repeat (4) @(posedge clk);
      #1 chk(16'({cen, sen, oen}), 16'h0007);
   endtask

   initial
   begin
      {wr, rd, ovf, go_idle, irq, addr, wdata} = '0;
      error_cnt = 0;
      samples_checked = 0;
      pin_n  = 1'b1;
      pins   = 15'h7fff;
      dbg    = '0;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // reset values and an unmapped word
      rd_chk(4'h0, 16'h0000, 16'hffff);
      rd_chk(4'h1, 16'h00fc, 16'hffff);
      rd_chk(4'h2, 16'h0000, 16'hffff);
      rd_chk(4'h3, 16'h0001, 16'hffff);
      rd_chk(4'h4, 16'h0000, 16'hffff);
      wr_reg(4'h0, 16'h002d);
      rd_chk(4'h0, 16'h0005, 16'hffff);
      // prescale codes
      wr_reg(4'h0, 16'h0028);
      period(512);
      wr_reg(4'h0, 16'h002a);
      wait_tick(n);
      period(1024);
      wr_reg(4'h0, 16'h0029);
      wait_tick(n);
      period(512);
      // debug conditions on the count tick
      @(posedge clk) dbg <= 5'b10000;
      cnt_tick(1100, n);
      chk(16'(n), 16'h0000);
      @(posedge clk) dbg <= 5'b11000;
      period(512);
      @(posedge clk) dbg <= 5'b10010;
      period(512);
      @(posedge clk) dbg <= 5'b00100;
      cnt_tick(1100, n);
      chk(16'(n), 16'h0000);
      @(posedge clk) dbg <= 5'b00000;
      // disable bit with and without override
      wr_reg(4'h0, 16'h0068);
      rd_chk(4'h0, 16'h0040, 16'hffff);
      @(posedge clk) ovf <= 1'b1;
      @(posedge clk) ovf <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(16'(pulse_n), 16'h0001);
      wr_reg(4'h3, 16'h0000);
      wr_reg(4'h0, 16'h0028);
      rd_chk(4'h0, 16'h0040, 16'hffff);
      wr_reg(4'h3, 16'h0003);
      wr_reg(4'h0, 16'h0028);
      rd_chk(4'h0, 16'h0000, 16'hffff);
      // a fire, its pulse and the latched flag
      @(posedge clk) ovf <= 1'b1;
      @(posedge clk) ovf <= 1'b0;
      lowcnt(np, ni);
      chk(16'(np), 16'h0200);
      chk(16'(ni), 16'h0200);
      repeat (10) @(posedge clk);
      rd_chk(4'h0, 16'h0080, 16'h0080);
      wr_reg(4'h0, 16'h002b);
      rd_chk(4'h0, 16'h0083, 16'hffff);
      wr_reg(4'h0, 16'h00ab);
      rd_chk(4'h0, 16'h0003, 16'hffff);
      // bad check pattern while enabled
      wr_reg(4'h0, 16'h0000);
      #1 chk(16'(crr), 16'h0001);
      lowcnt(np, ni);
      chk(16'(np), 16'h0200);
      rd_chk(4'h0, 16'h0003, 16'h0007);
      // pulse seen with the board reset low leaves no flag
      @(posedge clk) pin_n <= 1'b0;
      @(posedge clk) ovf <= 1'b1;
      @(posedge clk) ovf <= 1'b0;
      lowcnt(np, ni);
      repeat (10) @(posedge clk);
      pin_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd_chk(4'h0, 16'h0000, 16'h0080);
      // idle keeps every clock on, an interrupt ends it
      wr_reg(4'h2, 16'h0001);
      enter(16'h0000, 3'b111);
      @(posedge clk) irq <= 1'b1;
      @(posedge clk) irq <= 1'b0;
      repeat (4) @(posedge clk);
      // standby: unselected pin, short glitch, then a real wake
      enter(16'h0001, 3'b001);
      @(posedge clk) pins <= 15'h5fff;
      repeat (10) @(posedge clk);
      #1 chk(16'(cen), 16'h0000);
      @(posedge clk) pins <= 15'h7ffe;
      @(posedge clk) pins <= 15'h7fff;
      repeat (8) @(posedge clk);
      #1 chk(16'(cen), 16'h0000);
      wake_by(15'h7ffe);
      enter(16'h0001, 3'b001);
      @(posedge clk) dbg <= 5'b00001;
      wait_en();
      @(posedge clk) dbg <= 5'b00000;
      repeat (4) @(posedge clk);
      // halt: only nmi, reset pin or debugger
      enter(16'h0002, 3'b000);
      @(posedge clk) pins <= 15'h7ffe;
      repeat (10) @(posedge clk);
      #1 chk(16'(cen), 16'h0000);
      wake_by(15'h7ffd);
      end_sim();
   end
endmodule
`default_nettype wire
